/* inc/wdcm_pkg.sv */
/*
 Shared constants, field layouts and carrier types for the windowed
 watchdog with clock monitor. Assumes a 100 MHz reference clock and an
 8-bit register port in the same clock domain.
*/
package wdcm_pkg;
   // ------------------------------------------------------------
   // Register map and field layout
   // ------------------------------------------------------------
   localparam logic [7:0] SVC_ADDR = 8'h00;
   localparam int WIN_MSB = 7;
   localparam int WIN_LSB = 6;
   localparam int KEY_MSB = 5;
   localparam int KEY_LSB = 1;
   localparam int CM_BIT = 0;
   localparam logic [4:0] SVC_KEY = 5'h0c;
   localparam logic [4:0] KEY_READ = 5'h00;
   localparam logic [1:0] WIN_RESET = 2'h3;
   localparam logic CM_RESET = 1'b1;
   localparam int OPT_WD_DIS_BIT = 2;
   localparam logic [7:0] RD_IDLE = 8'h00;

   // ------------------------------------------------------------
   // Timing, in instruction cycles unless named otherwise
   // ------------------------------------------------------------
   localparam logic [16:0] LOWER_TC = 17'h0_0100;
   localparam logic [16:0] UPPER_BASE_TC = 17'h0_2000;
   localparam logic [4:0] HOLD_TC = 5'h18;
   localparam logic [3:0] CKI_PER_TC = 4'ha;
   localparam logic [1:0] SETTLE_CYC = 2'h3;
   localparam int CLK_MHZ = 100;
   localparam int CM_LIMIT_US = 1000;
   localparam int CM_LIMIT_CYC = CM_LIMIT_US * CLK_MHZ;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdcm_bus_t;

   typedef struct packed {
      logic out;
      logic oe_b;
      logic pullup_en;
   } wdcm_pad_t;

   typedef enum logic [4:0] {
      WD_START = 5'b0_0001,
      WD_RUN = 5'b0_0010,
      WD_SENSE = 5'b0_0100,
      WD_HOLD = 5'b0_1000,
      WD_REL = 5'b1_0000
   } wdcm_state_t;
endpackage

/* test/wdcm_assertions.sv */
/*
 Concurrent checks on the watchdog and clock monitor top ports.
 Assumes one clock domain, rst_b synchronous active low.
*/
`timescale 1ns/100ps
module wdcm_assertions #(
   parameter int CM_LIMIT = 100000
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire wdcm_pkg::wdcm_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic clock_input_pin,
   input wire logic [7:0] option_config_reg,
   input wire logic halt_mode,
   input wire logic idle_mode,
   input wire logic fault_in,
   input wire wdcm_pkg::wdcm_pad_t fault_out_pin,
   input wire logic port_g_pin_one_sel,
   input wire logic clk_fail
);
   import wdcm_pkg::*;
   // -------------------------
   // Helpers and properties
   // -------------------------
   logic [2:0] osc_sync;
   logic [3:0] osc_div;
   int stall_cnt;
   int hi_cnt;
   // Own instruction cycle view: ten rising oscillator edges per cycle, so the
   // stall is timed from the last whole cycle, not the last edge
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         osc_sync <= 3'h0;
         osc_div <= 4'h0;
         stall_cnt <= 0;
      end else begin
         osc_sync <= {osc_sync[1:0], clock_input_pin};
         if (osc_sync[1] && !osc_sync[2]) begin
            osc_div <= (osc_div == CKI_PER_TC - 4'h1) ? 4'h0
               : osc_div + 4'h1;
         end
         stall_cnt <= (osc_sync[1] && !osc_sync[2]
            && osc_div == CKI_PER_TC - 4'h1) ? 0 : stall_cnt + 1;
      end
   end
   // Cycles of a settled, released pin, so the sequencer is surely running
   always_ff @(posedge clock) begin
      if (!rst_b || !fault_out_pin.oe_b || !fault_in)
         hi_cnt <= 0;
      else if (hi_cnt < 15)
         hi_cnt <= hi_cnt + 1;
   end
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_BAD_KEY:
   assert property (bus.wr && bus.addr == SVC_ADDR && hi_cnt >= 8
      && bus.wdata[KEY_MSB:KEY_LSB] != SVC_KEY && !halt_mode && !idle_mode
      && !option_config_reg[OPT_WD_DIS_BIT] |-> ##2 !fault_out_pin.oe_b)
      else $error("bad key write did not drive the fault pin");
   AST_RD_KEY:
   assert property (bus.rd |=> rdata[KEY_MSB:KEY_LSB] == KEY_READ)
      else $error("key field visible on read");
   AST_RD_OTHER:
   assert property (!bus.rd || bus.addr != SVC_ADDR |=> rdata == RD_IDLE)
      else $error("read data not zero");
   AST_OUT_LOW:
   assert property (fault_out_pin.out == 1'b0)
      else $error("fault pin drives high");
   AST_PULL_OFF:
   assert property (!fault_out_pin.oe_b |-> !fault_out_pin.pullup_en)
      else $error("pull-up on while driving low");
   AST_NO_EARLY_REL:
   assert property ($fell(fault_out_pin.oe_b) |=> !fault_out_pin.oe_b [*8])
      else $error("fault pin released too soon");
   AST_REL_PULL:
   assert property ($rose(fault_out_pin.oe_b) |-> fault_out_pin.pullup_en)
      else $error("released pin without pull-up");
   AST_CM_PIN:
   assert property (clk_fail |-> ##[0:1] !fault_out_pin.oe_b)
      else $error("clock fail without pin low");
   AST_CM_SLOW:
   assert property ($rose(clk_fail) |-> stall_cnt >= CM_LIMIT - 4)
      else $error("clock flagged while running");
   AST_RESET_QUIET:
   assert property (disable iff (1'b0) !rst_b |=> fault_out_pin.oe_b
      && !clk_fail && !port_g_pin_one_sel)
      else $error("detection active in reset");
   AST_SEL:
   assert property ($past(rst_b, 3) && option_config_reg ==
      $past(option_config_reg, 3) |-> port_g_pin_one_sel ==
      !option_config_reg[OPT_WD_DIS_BIT])
      else $error("pin function select wrong");
   cover property ($fell(fault_out_pin.oe_b));
   cover property ($rose(clk_fail));
   cover property (bus.rd ##1 rdata != RD_IDLE);
endmodule // wdcm_assertions

bind wdcm_watchdog_clock_monitor wdcm_assertions #(
   .CM_LIMIT(CM_LIMIT)
) wdcm_assertions_inst (
   .clock(clock),
   .rst_b(rst_b),
   .bus(bus),
   .rdata(rdata),
   .clock_input_pin(clock_input_pin),
   .option_config_reg(option_config_reg),
   .halt_mode(halt_mode),
   .idle_mode(idle_mode),
   .fault_in(fault_in),
   .fault_out_pin(fault_out_pin),
   .port_g_pin_one_sel(port_g_pin_one_sel),
   .clk_fail(clk_fail)
);

/* test/wdcm_pin_model.sv */
/*
 Board side of the fault pin: a reset line with its own pull-up.
 Assumes the pad struct of the watchdog top module.
*/
`timescale 1ns/100ps
module wdcm_pin_model (
   input wire wdcm_pkg::wdcm_pad_t pad,
   output logic level
);
   import wdcm_pkg::*;
   // -------------------------
   // Line level
   // -------------------------
   // Board pull-up holds the line high whenever the pad lets go
   assign level = pad.oe_b ? 1'b1 : pad.out;
endmodule // wdcm_pin_model

/* test/wdcm_watchdog_clock_monitor_bench.sv */
/*
 Self-checking bench for the watchdog and clock monitor.
 Assumes the pin model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module wdcm_watchdog_clock_monitor_bench;
   import wdcm_pkg::*;
   // -------------------------
   // Stimulus and tasks
   // -------------------------
   logic clock, rst_b, osc, osc_run, halt_mode, idle_mode, fault_in;
   logic port_g_pin_one_sel, clk_fail;
   logic [7:0] rdata, option_config_reg, rd_val;
   wdcm_bus_t bus;
   wdcm_pad_t pad;
   int error_cnt, checked, cnt;
   logic [7:0] bad_tbl [4] = '{8'h59, 8'h1d, 8'h18, 8'hd9};
   wdcm_watchdog_clock_monitor #(.CM_LIMIT(200))
      wdcm_watchdog_clock_monitor_inst (.clock(clock), .rst_b(rst_b),
      .bus(bus), .rdata(rdata), .clock_input_pin(osc),
      .option_config_reg(option_config_reg), .halt_mode(halt_mode),
      .idle_mode(idle_mode), .fault_in(fault_in), .fault_out_pin(pad),
      .port_g_pin_one_sel(port_g_pin_one_sel), .clk_fail(clk_fail));
   wdcm_pin_model wdcm_pin_model_inst (.pad(pad), .level(fault_in));
   // Reference clock, and an oscillator of unrelated phase
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always #14.7 if (osc_run) osc = ~osc;
   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_rng(input string n, input int lo, input int hi,
      input int g);
      checked++;
      if (g < lo || g > hi) begin
         error_cnt++;
         $display("FAIL %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 rd_val = rdata;
   endtask
   // One instruction cycle is ten rising oscillator edges, about 30 clocks
   task automatic wait_tc(input int n);
      repeat (n * 30) @(posedge clock);
   endtask
   task automatic wait_oe(input logic v, input int lim);
      cnt = 0;
      while (pad.oe_b !== v && cnt < lim) begin
         @(posedge clock);
         #1 cnt++;
      end
   endtask
   task automatic expect_fault(input string n);
      wait_oe(1'b0, 8);
      chk(n, 8'h00, {7'h00, pad.oe_b});
      wait_oe(1'b1, 2000);
      chk_rng(n, 16 * 27, 32 * 30 + 40, cnt);
      repeat (8) @(posedge clock);
   endtask
   task automatic quiet(input string n, input int cycles);
      cnt = 0;
      repeat (cycles) begin
         @(posedge clock);
         #1 if (pad.oe_b !== 1'b1) cnt++;
      end
      chk_rng(n, 0, 0, cnt);
   endtask
   task automatic t_reset;
      rd(SVC_ADDR);
      chk("reset read", 8'hc1, rd_val);
      rd(8'h05);
      chk("unmapped", 8'h00, rd_val);
      chk("pad", 8'h07, {5'h00, port_g_pin_one_sel, pad.pullup_en,
         pad.oe_b});
   endtask
   // Early first service is legal; an early second one is not
   task automatic t_first;
      wr(SVC_ADDR, 8'h19);
      rd(SVC_ADDR);
      chk("config", 8'h01, rd_val);
      wr(SVC_ADDR, 8'h19);
      repeat (20) @(posedge clock);
      wr(SVC_ADDR, 8'h19);
      expect_fault("early");
      wait_tc(260);
      wr(SVC_ADDR, 8'h19);
      quiet("valid", 300);
   endtask
   task automatic t_bad;
      foreach (bad_tbl[i]) begin
         wait_tc(260);
         wr(SVC_ADDR, bad_tbl[i]);
         expect_fault("mismatch");
         rd(SVC_ADDR);
         chk("locked", 8'h01, rd_val);
      end
   endtask
   // Halt freezes the window and idle exit restarts it, so a service
   // that would be late enough without them comes too early here
   task automatic t_low;
      wait_tc(260);
      wr(SVC_ADDR, 8'h19);
      @(posedge clock);
      halt_mode <= 1'b1;
      wait_tc(300);
      @(posedge clock);
      halt_mode <= 1'b0;
      wr(SVC_ADDR, 8'h19);
      expect_fault("halt freeze");
      wait_tc(100);
      @(posedge clock);
      idle_mode <= 1'b1;
      repeat (4) @(posedge clock);
      idle_mode <= 1'b0;
      wait_tc(200);
      wr(SVC_ADDR, 8'h19);
      expect_fault("idle exit");
   endtask
   task automatic t_clkmon;
      osc_run = 1'b0;
      wait_oe(1'b0, 400);
      repeat (4) @(posedge clock);
      chk("cm", 8'h02, {6'h00, clk_fail, pad.oe_b});
      repeat (500) @(posedge clock);
      chk("cm stay", 8'h02, {6'h00, clk_fail, pad.oe_b});
      osc_run = 1'b1;
      wait_oe(1'b1, 2000);
      chk_rng("cm release", 16 * 27, 32 * 30 + 40, cnt);
      repeat (8) @(posedge clock);
   endtask
   task automatic t_dis;
      @(posedge clock);
      option_config_reg <= 8'h04;
      repeat (4) @(posedge clock);
      #1 chk("off", 8'h00, {6'h00, port_g_pin_one_sel,
         pad.pullup_en});
      wr(SVC_ADDR, 8'h00);
      quiet("off write", 50);
   endtask
   task automatic results;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      bus = '0;
      option_config_reg = 8'h00;
      halt_mode = 1'b0;
      idle_mode = 1'b0;
      osc = 1'b0;
      osc_run = 1'b1;
      rst_b = 1'b0;
      error_cnt = 0;
      checked = 0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      repeat (6) @(posedge clock);
      t_reset;
      t_first;
      t_bad;
      t_low;
      t_clkmon;
      t_dis;
      results;
   end
   // Cut a hang short at 100k cycles, beyond the expected 72k or so
   initial begin
      #1000000;
      error_cnt++;
      results;
   end
endmodule // wdcm_watchdog_clock_monitor_bench

/* verilog/wdcm_watchdog_clock_monitor.sv */
/*
 Windowed watchdog and clock monitor sharing one active-low fault pin.
 Assumes: clock is a free running 100 MHz reference independent of the
 instruction clock; the oscillator input and the fault pin level come
 from outside and are synchronised here; the register port, option
 configuration and low-power mode flags come from logic on clock.
*/
// The strobed register port and the placing of the registers were decided locally.
// Functional notes
// - Key field bits 5..1 must equal 01100 for a valid service.
// - Service register: window select 7..6, key 5..1, monitor enable 0.
// - Window select 00..11 gives upper limits 8k, 16k, 32k, 64k cycles.
// - Lower limit 256 cycles; servicing sooner is an error.
// - Monitor enable bit one turns clock monitoring on, zero off.
// - Detection inhibited in reset; reset arms with window 11, monitor on.
// - First keyed write after reset fixes window and monitor choice.
// - Later writes compare bits 7..0 against stored window, key and monitor enable.
// - Full match restarts window; any field mismatch raises fault.
// - Upper limit expiring without service raises fault.
// - First configuring write also counts as a service.
// - Fault pin active low with weak pull-up when inactive.
// - Fault held low 16..32 cycles after pin sensed low, then released.
// - Service window restarts when fault pin returns high; code does so only after a watchdog fault, not a clock monitor fault.
// - Service writes during an active fault are ignored; code ignores them in a watchdog fault only, not a clock monitor fault.
// - Pin low at start runs the timeout sequence, then goes high.
// - Slow clock holds pin low; release 16..32 cycles after recovery.
// - Never flag above 10 kHz; always flag below 10 Hz.
// - Option bit 2 low enables watchdog and fault pin function.
// - Clock never reaching minimum rate after reset gives steady error.
// - Key field reads back as zeros.
// - Watchdog frozen in halt and idle; monitor keeps running.
// - Leaving idle performs an automatic service.
`timescale 1ns/100ps
module wdcm_watchdog_clock_monitor #(
   parameter int CM_LIMIT = wdcm_pkg::CM_LIMIT_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire wdcm_pkg::wdcm_bus_t bus,
   output logic [7:0] rdata,
   input wire logic clock_input_pin,
   input wire logic [7:0] option_config_reg,
   input wire logic halt_mode,
   input wire logic idle_mode,
   input wire logic fault_in,
   output wdcm_pkg::wdcm_pad_t fault_out_pin,
   output logic port_g_pin_one_sel,
   output logic clk_fail
);
   import wdcm_pkg::*;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic key_match(input logic [7:0] d);
      key_match = (d[KEY_MSB:KEY_LSB] == SVC_KEY);
   endfunction

   function automatic logic [16:0] upper_limit(input logic [1:0] w);
      upper_limit = UPPER_BASE_TC << w;
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic cki_s1;
   logic cki_s2;
   logic cki_s3;
   logic fin_s1;
   logic fin_s2;
   logic [3:0] cki_div;
   logic tc_tick;
   logic [19:0] cm_cnt;
   logic cm_slow;
   logic [4:0] cm_hold;
   logic [1:0] win_sel;
   logic cm_en;
   logic configured;
   wdcm_state_t state;
   wdcm_state_t next_state;
   logic [16:0] wd_cnt;
   logic [4:0] hold_cnt;
   logic [1:0] settle;
   logic idle_q;
   logic wd_en;
   logic svc_wr;
   logic svc_good;
   logic svc_bad;
   logic hw_service;
   logic lower_ok;
   logic upper_hit;
   logic cm_drive;
   logic next_drive;

   assign wd_en = ~option_config_reg[OPT_WD_DIS_BIT];

   // ------------------------------------------------------------
   // Synchronisers for the two outside inputs
   // ------------------------------------------------------------
   // Pin levels are asynchronous to the reference clock
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cki_s1 <= 1'b0;
         cki_s2 <= 1'b0;
         cki_s3 <= 1'b0;
         fin_s1 <= 1'b1;
         fin_s2 <= 1'b1;
      end else begin
         cki_s1 <= clock_input_pin;
         cki_s2 <= cki_s1;
         cki_s3 <= cki_s2;
         fin_s1 <= fault_in;
         fin_s2 <= fin_s1;
      end
   end

   // ------------------------------------------------------------
   // Instruction cycle enable from the oscillator input
   // ------------------------------------------------------------
   // One tick per ten rising oscillator edges; a stopped oscillator gives none
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cki_div <= '0;
         tc_tick <= 1'b0;
      end else begin
         tc_tick <= 1'b0;
         if (cki_s2 && !cki_s3) begin
            if (cki_div == CKI_PER_TC - 4'h1) begin
               cki_div <= '0;
               tc_tick <= 1'b1;
            end else begin
               cki_div <= cki_div + 4'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Clock monitor
   // ------------------------------------------------------------
   // Reference cycles since the last instruction cycle; the limit sits
   // at a 1 ms period, well inside the 100 us .. 100 ms band
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cm_cnt <= '0;
         cm_slow <= 1'b0;
      end else if (tc_tick) begin
         cm_cnt <= '0;
         cm_slow <= 1'b0;
      end else if (cm_cnt >= 20'(CM_LIMIT - 1)) begin
         cm_slow <= 1'b1;
      end else begin
         cm_cnt <= cm_cnt + 20'h1;
      end
   end

   // Release delay counted in instruction cycles after recovery
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cm_hold <= '0;
      end else if (cm_slow) begin
         cm_hold <= HOLD_TC;
      end else if (tc_tick && cm_hold != 5'h0) begin
         cm_hold <= cm_hold - 5'h1;
      end
   end

   // Monitor still runs in halt and idle; only wd_en and cm_en gate it
   assign cm_drive = wd_en && cm_en && (cm_slow || cm_hold != 5'h0);

   // ------------------------------------------------------------
   // Service decode
   // ------------------------------------------------------------
   assign svc_wr = bus.wr && bus.addr == SVC_ADDR && wd_en;
   assign lower_ok = wd_cnt >= LOWER_TC;
   assign upper_hit = wd_cnt >= upper_limit(win_sel);

   // Initial service needs only the key, and may come inside 256 cycles
   always_comb begin
      svc_good = 1'b0;
      svc_bad = 1'b0;
      if (svc_wr && state == WD_RUN) begin
         if (!configured) begin
            svc_good = key_match(bus.wdata);
         end else begin
            svc_good = key_match(bus.wdata)
               && bus.wdata[WIN_MSB:WIN_LSB] == win_sel
               && bus.wdata[CM_BIT] == cm_en && lower_ok;
         end
         svc_bad = !svc_good;
      end
   end

   // Automatic service on the falling edge of idle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         idle_q <= 1'b0;
      end else begin
         idle_q <= idle_mode;
      end
   end
   assign hw_service = idle_q && !idle_mode;

   // ------------------------------------------------------------
   // Configuration latched once after reset
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         win_sel <= WIN_RESET;
         cm_en <= CM_RESET;
         configured <= 1'b0;
      end else if (svc_good && !configured) begin
         win_sel <= bus.wdata[WIN_MSB:WIN_LSB];
         cm_en <= bus.wdata[CM_BIT];
         configured <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Watchdog sequencer
   // ------------------------------------------------------------
   // Start waits for the pin synchroniser to fill before judging it
   always_comb begin
      next_state = state;
      unique case (state)
         WD_START: begin
            if (settle == SETTLE_CYC) begin
               next_state = fin_s2 ? WD_RUN : WD_SENSE;
            end
         end
         WD_RUN: begin
            if (wd_en && (svc_bad || (upper_hit && !halt_mode
               && !idle_mode))) begin
               next_state = WD_SENSE;
            end
         end
         WD_SENSE: begin
            if (!fin_s2) begin
               next_state = WD_HOLD;
            end
         end
         WD_HOLD: begin
            if (hold_cnt == HOLD_TC) begin
               next_state = WD_REL;
            end
         end
         WD_REL: begin
            if (fin_s2) begin
               next_state = WD_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= WD_START;
      end else begin
         state <= next_state;
      end
   end

   // Settle counter used only on the way out of reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         settle <= '0;
      end else if (state == WD_START && settle != SETTLE_CYC) begin
         settle <= settle + 2'h1;
      end
   end

   // Hold timer counts instruction cycles once the pin reads low
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         hold_cnt <= '0;
      end else if (state != WD_HOLD) begin
         hold_cnt <= '0;
      end else if (tc_tick) begin
         hold_cnt <= hold_cnt + 5'h1;
      end
   end

   // Window counter; frozen in low-power modes, saturates at the top
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wd_cnt <= '0;
      end else if (state != WD_RUN || svc_good || hw_service) begin
         wd_cnt <= '0;
      end else if (tc_tick && !halt_mode && !idle_mode
         && !upper_hit) begin
         wd_cnt <= wd_cnt + 17'h1;
      end
   end

   // ------------------------------------------------------------
   // Fault pin drive
   // ------------------------------------------------------------
   // Pull-up is on only while the pin is not driven low
   assign next_drive = cm_drive
      || (wd_en && (state == WD_SENSE || state == WD_HOLD));

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         fault_out_pin.out <= 1'b0;
         fault_out_pin.oe_b <= 1'b1;
         fault_out_pin.pullup_en <= 1'b0;
         port_g_pin_one_sel <= 1'b0;
         clk_fail <= 1'b0;
      end else begin
         fault_out_pin.out <= 1'b0;
         fault_out_pin.oe_b <= !next_drive;
         fault_out_pin.pullup_en <= wd_en && !next_drive;
         port_g_pin_one_sel <= wd_en;
         clk_fail <= cm_drive;
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   // Hiding the key keeps a runaway loop from copying it back
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdata <= RD_IDLE;
      end else if (bus.rd && bus.addr == SVC_ADDR) begin
         rdata <= {win_sel, KEY_READ, cm_en};
      end else begin
         rdata <= RD_IDLE;
      end
   end

endmodule // wdcm_watchdog_clock_monitor
